// ---- rtl/redriver_map.svh ----
// offsets, field positions, reset values and timing figures of the redriver control
`ifndef REDRIVER_MAP_SVH
`define REDRIVER_MAP_SVH

// ****************************************************************
// clock and timing figures
// ****************************************************************
`define CLK_KHZ 100000
`define IDLE_TYP_MS 300
`define IDLE_MAX_MS 400
`define RECFG_MAX_MS 100
`define WAKE_SETTLE_MS 20
`define DET_PERIOD_MS 1
`define FILT_MS 1

// ****************************************************************
// register offsets and fields
// ****************************************************************
`define ADR_CTRL 8'h00
`define ADR_STATUS 8'h04
`define ADR_CONFIG 8'h08
`define CTRL_SLEEP_BIT 0
`define CTRL_RESET 1'b0
`define STAT_CE_BIT 6

// ****************************************************************
// level codes: gain in half dB, emphasis in half dB of attenuation
// ****************************************************************
`define GAIN_LL 5'h12
`define GAIN_LH 5'h06
`define GAIN_HL 5'h0c
`define GAIN_HH 5'h0f
`define EMPH_LL 5'h07
`define EMPH_LH 5'h00
`define EMPH_HL 5'h0e
`define EMPH_HH 5'h0a

`endif

// ---- rtl/redriver_pkg.sv ----
// types shared by the redriver control files
package redriver_pkg;

  typedef enum logic [1:0] {
    ST_DEEP = 2'b00,
    ST_WAKE = 2'b01,
    ST_SAVE = 2'b11,
    ST_ACTIVE = 2'b10
  } pwr_state_e;

  typedef logic [24:0] tmr_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_s;

  typedef struct packed {
    pwr_state_e st;
    logic chan_en;
    logic fwd;
    logic det_start;
    logic cm_hold;
    logic term_hiz;
    logic ready;
  } port_ctl_s;

  typedef struct packed {
    pwr_state_e st;
    logic conn;
    logic det_busy;
    tmr_t tmr;
    tmr_t det_tmr;
  } port_st_s;

  typedef struct packed {
    logic [1:0] gain_sel;
    logic [1:0] emph_sel;
  } grp_cfg_s;

  typedef struct packed {
    logic [4:0] gain_hdb;
    logic [4:0] emph_hdb;
  } grp_lvl_s;

endpackage

// ---- rtl/cfg_pin_filter.sv ----
// synchroniser and stability filter for the configuration strap pins
`timescale 1ns/1ns
`include "redriver_map.svh"
module cfg_pin_filter import redriver_pkg::*; #(
  parameter int unsigned FILT_CYCLES = `FILT_MS * `CLK_KHZ
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // raw pins and accepted value
  input wire logic [7:0] pins,
  output logic [7:0] pins_q
);

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] held;
    tmr_t cnt;
  } filt_s;

  filt_s filt_reg;
  filt_s filt_next;

  // a new value is taken only after it stood unchanged for the whole window
  always_comb begin
    filt_next = filt_reg;
    filt_next.s1 = pins;
    filt_next.s2 = filt_reg.s1;
    filt_next.s3 = filt_reg.s2;
    if (filt_reg.s2 == filt_reg.held) begin
      filt_next.cnt = '0;
    end else if (filt_reg.s2 != filt_reg.s3) begin
      // first stage may be unsettled, so only later stages feed the window
      filt_next.cnt = '0;
    end else if (filt_reg.cnt == tmr_t'(FILT_CYCLES - 1)) begin
      filt_next.held = filt_reg.s2;
      filt_next.cnt = '0;
    end else begin
      filt_next.cnt = filt_reg.cnt + tmr_t'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      filt_reg <= '0;
    end else begin
      filt_reg <= filt_next;
    end
  end

  assign pins_q = filt_reg.held;

  a_filt_accept: assert property (@(posedge core_clk)
    disable iff (reset)
    (filt_reg.held != $past(filt_reg.held)) |->
      $past(filt_reg.cnt) == tmr_t'(FILT_CYCLES - 1))
    else $error("strap value accepted before the filter window ran out");

endmodule

// ---- rtl/setting_decode.sv ----
// decode of one group's gain and emphasis select pairs
`timescale 1ns/1ns
`include "redriver_map.svh"
module setting_decode import redriver_pkg::*; (
  // strap pairs in, levels out
  input wire grp_cfg_s cfg,
  output grp_lvl_s lvl
);

  always_comb begin
    case (cfg.gain_sel)
      2'b00: lvl.gain_hdb = `GAIN_LL;
      2'b01: lvl.gain_hdb = `GAIN_LH;
      2'b10: lvl.gain_hdb = `GAIN_HL;
      2'b11: lvl.gain_hdb = `GAIN_HH;
      default: lvl.gain_hdb = `GAIN_LL;
    endcase
    case (cfg.emph_sel)
      2'b00: lvl.emph_hdb = `EMPH_LL;
      2'b01: lvl.emph_hdb = `EMPH_LH;
      2'b10: lvl.emph_hdb = `EMPH_HL;
      2'b11: lvl.emph_hdb = `EMPH_HH;
      default: lvl.emph_hdb = `EMPH_LL;
    endcase
  end

endmodule

// ---- rtl/redriver_config_power_state.sv ----
// strap decode and per-port power state control of a dual port redriver
//
// Implementation choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ns
`include "redriver_map.svh"
module redriver_config_power_state import redriver_pkg::*; #(
  parameter int unsigned IDLE_CYCLES = `IDLE_TYP_MS * `CLK_KHZ,
  parameter int unsigned WAKE_CYCLES = `WAKE_SETTLE_MS * `CLK_KHZ,
  parameter int unsigned DET_CYCLES = `DET_PERIOD_MS * `CLK_KHZ,
  parameter int unsigned FILT_CYCLES = `FILT_MS * `CLK_KHZ
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // register bus
  input wire wb_req_s wb_req,
  output wb_rsp_s wb_rsp,
  // chip enable
  input wire logic chip_en,
  // configuration straps
  input wire logic grp_a_gain_sel_lo,
  input wire logic grp_a_gain_sel_hi,
  input wire logic grp_a_emph_sel_lo,
  input wire logic grp_a_emph_sel_hi,
  input wire logic grp_b_gain_sel_lo,
  input wire logic grp_b_gain_sel_hi,
  input wire logic grp_b_emph_sel_lo,
  input wire logic grp_b_emph_sel_hi,
  // bus condition per port
  input wire logic [1:0] bus_active,
  input wire logic [1:0] det_done,
  input wire logic [1:0] det_found,
  // controls per port
  output port_ctl_s [1:0] port_ctl,
  // decoded levels
  output grp_lvl_s grp_a_lvl,
  output grp_lvl_s grp_b_lvl
);

  typedef struct packed {
    port_st_s [1:0] p;
    port_ctl_s [1:0] ctl;
    grp_lvl_s a_lvl;
    grp_lvl_s b_lvl;
    logic sleep;
    logic ce_seen;
    logic ack;
    logic [31:0] rdat;
  } top_s;

  top_s top_reg;
  top_s top_next;

  logic [7:0] cfg_q;
  grp_cfg_s [1:0] grp_cfg;
  grp_lvl_s [1:0] grp_lvl;
  logic awake;
  logic wb_hit;

  // ****************************************************************
  // strap filtering and decode
  // ****************************************************************

  cfg_pin_filter #(
    .FILT_CYCLES(FILT_CYCLES)
  ) u_filter (
    .core_clk(core_clk),
    .reset(reset),
    .pins({grp_a_gain_sel_hi, grp_a_gain_sel_lo,
           grp_a_emph_sel_hi, grp_a_emph_sel_lo,
           grp_b_gain_sel_hi, grp_b_gain_sel_lo,
           grp_b_emph_sel_hi, grp_b_emph_sel_lo}),
    .pins_q(cfg_q)
  );

  // group 0 is channel group A, group 1 is channel group B
  assign grp_cfg[0] = cfg_q[7:4];
  assign grp_cfg[1] = cfg_q[3:0];

  for (genvar g = 0; g < 2; g++) begin : g_dec
    setting_decode u_dec (
      .cfg(grp_cfg[g]),
      .lvl(grp_lvl[g])
    );
  end

  // ****************************************************************
  // next state
  // ****************************************************************

  // chip enable is the only wake source besides the software sleep bit
  assign awake = chip_en & ~top_reg.sleep;
  assign wb_hit = wb_req.cyc & wb_req.stb & ~top_reg.ack;

  always_comb begin
    top_next = top_reg;
    top_next.a_lvl = grp_lvl[0];
    top_next.b_lvl = grp_lvl[1];
    top_next.ce_seen = chip_en;
    for (int i = 0; i < 2; i++) begin
      top_next.ctl[i].det_start = 1'b0;
      // only squelch, detect, enable, the sleep bit and the timers feed the choice of state
      case (top_reg.p[i].st)
        ST_DEEP: begin
          top_next.p[i].tmr = '0;
          top_next.p[i].conn = 1'b0;
          if (awake) begin
            top_next.p[i].st = ST_WAKE;
          end
        end
        ST_WAKE: begin
          // bias settling; readiness is withheld the whole time
          if (top_reg.p[i].tmr == tmr_t'(WAKE_CYCLES - 1)) begin
            top_next.p[i].st = ST_SAVE;
            top_next.p[i].tmr = '0;
            top_next.p[i].det_tmr = '0;
          end else begin
            top_next.p[i].tmr = top_reg.p[i].tmr + tmr_t'(1);
          end
        end
        ST_SAVE: begin
          if (top_reg.p[i].det_busy) begin
            if (det_done[i]) begin
              top_next.p[i].det_busy = 1'b0;
              top_next.p[i].conn = det_found[i];
            end
          end else if (top_reg.p[i].det_tmr ==
                       tmr_t'(DET_CYCLES - 1)) begin
            top_next.p[i].det_tmr = '0;
            top_next.p[i].det_busy = 1'b1;
            top_next.ctl[i].det_start = 1'b1;
          end else begin
            top_next.p[i].det_tmr = top_reg.p[i].det_tmr + tmr_t'(1);
          end
          if (top_reg.p[i].conn && bus_active[i]) begin
            top_next.p[i].st = ST_ACTIVE;
            top_next.p[i].tmr = '0;
            top_next.p[i].det_busy = 1'b0;
            top_next.ctl[i].det_start = 1'b0;
          end
        end
        ST_ACTIVE: begin
          if (bus_active[i]) begin
            top_next.p[i].tmr = '0;
          end else if (top_reg.p[i].tmr == tmr_t'(IDLE_CYCLES - 1)) begin
            top_next.p[i].st = ST_SAVE;
            top_next.p[i].tmr = '0;
            top_next.p[i].det_tmr = '0;
          end else begin
            top_next.p[i].tmr = top_reg.p[i].tmr + tmr_t'(1);
          end
        end
        default: begin
          top_next.p[i].st = ST_DEEP;
        end
      endcase
      if (!awake) begin
        top_next.p[i].st = ST_DEEP;
        top_next.p[i].conn = 1'b0;
        top_next.p[i].det_busy = 1'b0;
        top_next.p[i].tmr = '0;
        top_next.p[i].det_tmr = '0;
        top_next.ctl[i].det_start = 1'b0;
      end
      // outputs follow the state being entered, so they change with it
      top_next.ctl[i].st = top_next.p[i].st;
      top_next.ctl[i].chan_en = (top_next.p[i].st == ST_SAVE) ||
                                (top_next.p[i].st == ST_ACTIVE);
      top_next.ctl[i].fwd = (top_next.p[i].st == ST_ACTIVE);
      top_next.ctl[i].ready = (top_next.p[i].st == ST_ACTIVE);
      top_next.ctl[i].cm_hold = (top_next.p[i].st == ST_ACTIVE) ||
        ((top_next.p[i].st == ST_SAVE) && top_next.p[i].conn);
      // terminations stay floated until the bias has settled
      top_next.ctl[i].term_hiz = (top_next.p[i].st == ST_DEEP) ||
                                 (top_next.p[i].st == ST_WAKE);
    end

    // ****************************************************************
    // register bus slave
    // ****************************************************************
    top_next.ack = wb_hit;
    if (wb_hit && wb_req.we && wb_req.sel[0] &&
        (wb_req.adr == `ADR_CTRL)) begin
      top_next.sleep = wb_req.dat[`CTRL_SLEEP_BIT];
    end
    top_next.rdat = '0;
    if (wb_hit && !wb_req.we) begin
      case (wb_req.adr)
        `ADR_CTRL: begin
          top_next.rdat[`CTRL_SLEEP_BIT] = top_reg.sleep;
        end
        `ADR_STATUS: begin
          top_next.rdat[1:0] = top_reg.p[0].st;
          top_next.rdat[3:2] = top_reg.p[1].st;
          top_next.rdat[4] = top_reg.p[0].conn;
          top_next.rdat[5] = top_reg.p[1].conn;
          top_next.rdat[`STAT_CE_BIT] = top_reg.ce_seen;
        end
        `ADR_CONFIG: begin
          top_next.rdat[9:0] = top_reg.a_lvl;
          top_next.rdat[19:10] = top_reg.b_lvl;
          top_next.rdat[27:20] = cfg_q;
        end
        default: begin
          top_next.rdat = '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      top_reg <= '0;
      top_reg.sleep <= `CTRL_RESET;
      for (int i = 0; i < 2; i++) begin
        top_reg.ctl[i].term_hiz <= 1'b1;
      end
    end else begin
      top_reg <= top_next;
    end
  end

  assign port_ctl = top_reg.ctl;
  assign grp_a_lvl = top_reg.a_lvl;
  assign grp_b_lvl = top_reg.b_lvl;
  assign wb_rsp.ack = top_reg.ack;
  assign wb_rsp.dat = top_reg.rdat;

  // ****************************************************************
  // checks
  // ****************************************************************

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  a_gain_b_map: assert property (
    cfg_q[3:2] == 2'b11 |=> grp_b_lvl.gain_hdb == `GAIN_HH)
    else $error("group B gain code 11 not decoded to 7.5 dB");

  a_emph_b_map: assert property (
    cfg_q[1:0] == 2'b10 |=> grp_b_lvl.emph_hdb == `EMPH_HL)
    else $error("group B emphasis code 10 not decoded to -7 dB");

  a_gain_a_map: assert property (
    cfg_q[7:6] == 2'b00 |=> grp_a_lvl.gain_hdb == `GAIN_LL)
    else $error("group A gain code 00 not decoded to 9 dB");

  a_emph_a_map: assert property (
    cfg_q[5:4] == 2'b01 |=> grp_a_lvl.emph_hdb == `EMPH_LH)
    else $error("group A emphasis code 01 not decoded to 0 dB");

  for (genvar i = 0; i < 2; i++) begin : g_chk
    a_active_nodet: assert property (
      port_ctl[i].st == ST_ACTIVE |-> port_ctl[i].fwd &&
        !port_ctl[i].det_start && port_ctl[i].cm_hold)
      else $error("active port detecting or not forwarding");

    a_save_chan_on: assert property (
      port_ctl[i].st == ST_SAVE |-> port_ctl[i].chan_en &&
        !port_ctl[i].fwd && !port_ctl[i].term_hiz)
      else $error("saving port lost its channel enable");

    a_noconn_cm_off: assert property (
      port_ctl[i].st == ST_SAVE && !top_reg.p[i].conn |->
        !port_ctl[i].cm_hold)
      else $error("common mode held with no connection");

    a_conn_cm_held: assert property (
      port_ctl[i].st == ST_SAVE && top_reg.p[i].conn |->
        port_ctl[i].cm_hold)
      else $error("common mode dropped while connected");

    // a port about to go active abandons its poll, so that cycle is left out
    a_det_periodic: assert property (
      top_reg.p[i].st == ST_SAVE && !top_reg.p[i].det_busy &&
      !(top_reg.p[i].conn && bus_active[i]) &&
      top_reg.p[i].det_tmr == tmr_t'(DET_CYCLES - 1) && awake |=>
        port_ctl[i].det_start && top_reg.p[i].det_busy)
      else $error("termination poll not issued on period");

    a_deep_float: assert property (
      port_ctl[i].st == ST_DEEP |-> port_ctl[i].term_hiz &&
        !port_ctl[i].cm_hold && !port_ctl[i].chan_en)
      else $error("deep port not floated");

    // after the forced deep cycle only deep or the wake path may follow
    a_ce_low_deep: assert property (
      !chip_en |=> port_ctl[i].st == ST_DEEP ##1
        (port_ctl[i].st == ST_DEEP || port_ctl[i].st == ST_WAKE))
      else $error("port left deep saving with enable low");

    a_wake_hold: assert property (
      top_reg.p[i].st == ST_WAKE &&
      top_reg.p[i].tmr != tmr_t'(WAKE_CYCLES - 1) && awake |=>
        top_reg.p[i].st == ST_WAKE && !port_ctl[i].ready)
      else $error("wake left before the settle time");

    a_det_result: assert property (
      top_reg.p[i].st == ST_SAVE && top_reg.p[i].det_busy &&
      det_done[i] && awake |=>
        top_reg.p[i].conn == $past(det_found[i]))
      else $error("detect result not taken as connection");

    a_idle_exit: assert property (
      top_reg.p[i].st == ST_ACTIVE && !bus_active[i] && awake &&
      top_reg.p[i].tmr == tmr_t'(IDLE_CYCLES - 1) |=>
        port_ctl[i].st == ST_SAVE && !port_ctl[i].fwd)
      else $error("idle time expired but port stayed active");

    a_idle_stay: assert property (
      top_reg.p[i].st == ST_ACTIVE && bus_active[i] && awake |=>
        port_ctl[i].st == ST_ACTIVE && top_reg.p[i].tmr == '0)
      else $error("active port left active despite bus activity");

    c_reach_active: cover property (
      port_ctl[i].st == ST_SAVE ##1 port_ctl[i].st == ST_ACTIVE);

    c_idle_to_save: cover property (
      port_ctl[i].st == ST_ACTIVE ##1 port_ctl[i].st == ST_SAVE);

    c_det_found: cover property (
      top_reg.p[i].det_busy && det_done[i] && det_found[i]);
  end

  c_ce_drop: cover property (
    port_ctl[0].st == ST_ACTIVE ##1 !chip_en ##1 port_ctl[0].st == ST_DEEP);

  a_wb_ack_once: assert property (
    wb_rsp.ack |=> !wb_rsp.ack)
    else $error("bus ack held for more than one cycle");

endmodule

// ---- test/usb_link_partner.sv ----
// link partner model: answers termination detect and makes bus traffic
`timescale 1ns/1ns
module usb_link_partner import redriver_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // controls from the redriver
  input wire port_ctl_s [1:0] port_ctl,
  // scenario knobs: load on the far end, traffic wanted, answer delay
  input wire logic [1:0] load_present,
  input wire logic [1:0] traffic,
  input wire logic [3:0] det_lat,
  // bus condition seen by the redriver
  output logic [1:0] bus_active,
  output logic [1:0] det_done,
  output logic [1:0] det_found
);
  logic [3:0] cnt_reg [2];
  logic [1:0] pend_reg;

  always_ff @(posedge core_clk) begin
    for (int p = 0; p < 2; p++) begin
      det_done[p] <= 1'b0;
      // outside a report the found line is not held, so it wanders
      det_found[p] <= ~det_found[p];
      // only electrical activity is shown, never link messages
      bus_active[p] <= traffic[p] & load_present[p];
      if (reset) begin
        pend_reg[p] <= 1'b0;
        cnt_reg[p] <= 4'h0;
        det_found[p] <= 1'b0;
      end else if (port_ctl[p].det_start) begin
        pend_reg[p] <= 1'b1;
        cnt_reg[p] <= det_lat;
      end else if (pend_reg[p]) begin
        if (cnt_reg[p] == 4'h0) begin
          pend_reg[p] <= 1'b0;
          det_done[p] <= 1'b1;
          det_found[p] <= load_present[p];
        end else begin
          cnt_reg[p] <= cnt_reg[p] - 4'h1;
        end
      end
    end
  end
endmodule

// ---- test/tb_top.sv ----
// self-checking bench for the redriver strap decode and power control
`timescale 1ns/1ns
module tb_top import redriver_pkg::*;;
  localparam int IDLE = 40, WAKE = 20, DET = 10, FILT = 5;
  localparam logic [4:0] GAIN_T [4] = '{5'h12, 5'h06, 5'h0c, 5'h0f};
  localparam logic [4:0] EMPH_T [4] = '{5'h07, 5'h00, 5'h0e, 5'h0a};
  logic core_clk, reset, chip_en;
  wb_req_s wb_req;
  wb_rsp_s wb_rsp;
  logic [7:0] straps, s;
  logic [31:0] e;
  logic [1:0] bus_active, det_done, det_found, load_present, traffic;
  logic [3:0] det_lat;
  port_ctl_s [1:0] port_ctl;
  grp_lvl_s grp_a_lvl, grp_b_lvl;
  int fail_count = 0, n_tests = 0, seed = 60, starts0 = 0, n0, n;
  logic [31:0] exp_q[$], mask_q[$];

  redriver_config_power_state #(.IDLE_CYCLES(IDLE), .WAKE_CYCLES(WAKE),
    .DET_CYCLES(DET), .FILT_CYCLES(FILT)) dut (
    .core_clk(core_clk), .reset(reset), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .chip_en(chip_en),
    .grp_a_gain_sel_hi(straps[7]), .grp_a_gain_sel_lo(straps[6]),
    .grp_a_emph_sel_hi(straps[5]), .grp_a_emph_sel_lo(straps[4]),
    .grp_b_gain_sel_hi(straps[3]), .grp_b_gain_sel_lo(straps[2]),
    .grp_b_emph_sel_hi(straps[1]), .grp_b_emph_sel_lo(straps[0]),
    .bus_active(bus_active), .det_done(det_done), .det_found(det_found),
    .port_ctl(port_ctl), .grp_a_lvl(grp_a_lvl), .grp_b_lvl(grp_b_lvl));

  usb_link_partner partner (
    .core_clk(core_clk), .reset(reset), .port_ctl(port_ctl),
    .load_present(load_present), .traffic(traffic), .det_lat(det_lat),
    .bus_active(bus_active), .det_done(det_done), .det_found(det_found));

  // ****************************************************************
  // compare, report and bus tasks
  // ****************************************************************
  task automatic report_and_stop();
    if (fail_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check_reg(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_ctl(input string what, input logic [9:0] exp,
                           input logic [9:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one classic cycle; the note is queued before the request goes out
  task automatic wb_xfer(input logic we, input logic [7:0] adr,
                         input logic [31:0] dat, input logic [31:0] exp,
                         input logic [31:0] mask);
    int k;
    exp_q.push_back(exp);
    mask_q.push_back(mask);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (wb_rsp.ack !== 1'b1 && k < 50);
    if (k >= 50) begin
      fail_count++;
      report_and_stop();
    end
    wb_req <= '0;
    @(posedge core_clk);
  endtask

  task automatic wait_st(input int p, input pwr_state_e st, input int lim);
    int k;
    k = 0;
    while (port_ctl[p].st !== st && k < lim) begin
      @(posedge core_clk);
      k++;
    end
    if (k >= lim) begin
      fail_count++;
      report_and_stop();
    end
  endtask

  function automatic logic [31:0] cfg_exp(input logic [7:0] v);
    return {4'h0, v, GAIN_T[v[3:2]], EMPH_T[v[1:0]],
            GAIN_T[v[7:6]], EMPH_T[v[5:4]]};
  endfunction

  // ****************************************************************
  // result watcher and clock
  // ****************************************************************
  always @(posedge core_clk) begin
    if (port_ctl[0].det_start === 1'b1) starts0++;
    if (wb_rsp.ack === 1'b1) begin
      if (exp_q.size() == 0) begin
        check_reg("stray ack", 32'h0, 32'h1);
      end else begin
        check_reg("bus data", exp_q.pop_front(),
                  wb_rsp.dat & mask_q.pop_front());
      end
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    reset = 1'b1;
    chip_en = 1'b1; // outside keeps the part enabled
    straps = 8'h00;
    wb_req = '0;
    load_present = 2'b00;
    traffic = 2'b00;
    det_lat = 4'h0;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    // every code on all pairs, then random straps; a short glitch between
    for (int i = 0; i < 12; i++) begin
      s = (i < 4) ? {4{i[1:0]}} : 8'($random(seed));
      e = cfg_exp(s);
      straps <= s;
      repeat (FILT + 8) @(posedge core_clk);
      wb_xfer(1'b0, 8'h08, 32'h0, e, 32'hffffffff);
      straps <= ~s;
      repeat (2) @(posedge core_clk);
      straps <= s;
      repeat (FILT + 8) @(posedge core_clk);
      check_ctl("group a level", e[9:0], grp_a_lvl);
      check_ctl("group b level", e[19:10], grp_b_lvl);
    end
    // no load: saving with all channels on and detect polling
    wait_st(0, ST_SAVE, 200);
    wait_st(1, ST_SAVE, 200);
    for (int p = 0; p < 2; p++) begin
      check_ctl("chan_en", 10'(1), 10'(port_ctl[p].chan_en));
      check_ctl("cm_hold", 10'(0), 10'(port_ctl[p].cm_hold));
      check_ctl("term_hiz", 10'(0), 10'(port_ctl[p].term_hiz));
    end
    n0 = starts0;
    repeat (4 * DET) @(posedge core_clk);
    check_ctl("detect polls", 10'(1), 10'(starts0 - n0 >= 2));
    // load appears, answered slowly; connection keeps common mode
    load_present <= 2'b11;
    det_lat <= 4'h7;
    repeat (3 * DET + 20) @(posedge core_clk);
    for (int p = 0; p < 2; p++) begin
      check_ctl("cm_hold", 10'(1), 10'(port_ctl[p].cm_hold));
    end
    wb_xfer(1'b0, 8'h04, 32'h0, 32'h7f, 32'h7f);
    // traffic on port 0 only
    traffic <= 2'b01;
    wait_st(0, ST_ACTIVE, 10);
    n0 = starts0;
    repeat (3 * DET) @(posedge core_clk);
    check_ctl("fwd", 10'(1), 10'(port_ctl[0].fwd));
    check_ctl("ready", 10'(1), 10'(port_ctl[0].ready));
    check_ctl("no detect", 10'(0), 10'(starts0 - n0));
    check_ctl("port1 st", 10'(ST_SAVE), 10'(port_ctl[1].st));
    // activity stops: idle time then saving with common mode kept
    traffic <= 2'b00;
    n = 0;
    while (port_ctl[0].st !== ST_SAVE && n < IDLE + 20) begin
      @(posedge core_clk);
      n++;
    end
    check_ctl("idle wait", 10'(1), 10'(n >= IDLE && n <= IDLE + 4));
    check_ctl("fwd off", 10'(0), 10'(port_ctl[0].fwd));
    check_ctl("cm kept", 10'(1), 10'(port_ctl[0].cm_hold));
    // sleep bit forces deep; unmapped place reads zero and ignores writes
    traffic <= 2'b11;
    wb_xfer(1'b1, 8'h00, 32'h1, 32'h0, 32'h0);
    repeat (3) @(posedge core_clk);
    for (int p = 0; p < 2; p++) begin
      check_ctl("deep st", 10'(ST_DEEP), 10'(port_ctl[p].st));
      check_ctl("hiz", 10'(1), 10'(port_ctl[p].term_hiz));
      check_ctl("cm off", 10'(0), 10'(port_ctl[p].cm_hold));
    end
    wb_xfer(1'b0, 8'h04, 32'h0, 32'h40, 32'h4f);
    wb_xfer(1'b1, 8'h0c, 32'hffffffff, 32'h0, 32'h0);
    wb_xfer(1'b0, 8'h0c, 32'h0, 32'h0, 32'hffffffff);
    wb_xfer(1'b1, 8'h00, 32'h0, 32'h0, 32'h0);
    // chip enable low holds deep despite traffic and load
    chip_en <= 1'b0; // forced deep saving
    repeat (WAKE + 10) @(posedge core_clk);
    for (int p = 0; p < 2; p++) begin
      check_ctl("ce deep", 10'(ST_DEEP), 10'(port_ctl[p].st));
    end
    wb_xfer(1'b0, 8'h04, 32'h0, 32'h00, 32'h4f);
    chip_en <= 1'b1;
    wait_st(0, ST_WAKE, 5);
    check_ctl("wake hiz", 10'(1), 10'(port_ctl[0].term_hiz));
    wait_st(0, ST_SAVE, WAKE + 10);
    report_and_stop();
  end
endmodule
